// >>> switch_cfg_defs.svh
/*
 * register offsets, reset values, field positions and timing figures of the
 * switch configuration bank.
 * assumes the clock runs at 250 MHz.
 */
`ifndef SWITCH_CFG_DEFS_SVH
`define SWITCH_CFG_DEFS_SVH

// ******************************************************
// register offsets
// ******************************************************
`define OFS_HIGH_SPEED_MODE_CTRL 8'h00
`define OFS_AUXILIARY_MODE_CTRL 8'h01
`define OFS_RECEIVER_SETTINGS 8'h10
`define OFS_INPUT_TERMINATION_AB 8'h11
`define OFS_INPUT_TERMINATION_CD 8'h12
`define OFS_RECEIVE_EQUALIZER_AB 8'h13
`define OFS_RECEIVE_EQUALIZER_CD 8'h14
`define OFS_TRANSMITTER_SETTINGS 8'h20

// ******************************************************
// reset values
// ******************************************************
`define RST_HIGH_SPEED_MODE_CTRL 8'h40
`define RST_AUXILIARY_MODE_CTRL 8'h40
`define RST_RECEIVER_SETTINGS 8'h01
`define RST_INPUT_TERMINATION_AB 8'h00
`define RST_INPUT_TERMINATION_CD 8'h00
`define RST_RECEIVE_EQUALIZER_AB 8'h00
`define RST_RECEIVE_EQUALIZER_CD 8'h00
`define RST_TRANSMITTER_SETTINGS 8'h03

// ******************************************************
// writable bit masks
// ******************************************************
`define MASK_MODE_CTRL 8'h43
`define MASK_RECEIVER_SETTINGS 8'h01
`define MASK_FULL 8'hFF
`define MASK_TRANSMITTER_SETTINGS 8'h0F

// ******************************************************
// field positions and fixed values
// ******************************************************
`define BIT_ENABLE 6
`define SEL_HI 1
`define SEL_LO 0
`define BIT_TERM_MASTER 0
`define PE_HI 3
`define PE_LO 2
`define BIT_OUT_TERM 1
`define BIT_OUT_CURRENT 0
`define SLAVE_ADDR_UPPER 4'h9
`define READ_IDLE 8'h00

// ******************************************************
// timing
// ******************************************************
`define CLK_MHZ 250
`define UPDATE_DELAY_NS 1000
`define UPDATE_DELAY_CYC ((`UPDATE_DELAY_NS * `CLK_MHZ) / 1000)

`endif

// >>> switch_cfg_host.sv
/* host model: serial engine side issuing decoded register strobes.
   assumes a free clk from the bench and one request at a time. */
`timescale 1ns/1ps
`default_nettype none
module switch_cfg_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // a released bus shows the inverse, so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rvalid ? reg_rdata : 8'hXX;
    endtask
endmodule // switch_cfg_host
`default_nettype wire

// >>> switch_cfg_pkg.sv
/*
 * types shared by the switch configuration bank.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package switch_cfg_pkg;
    typedef logic [2:0] reg_idx_t;
    typedef logic [7:0] reg_byte_t;
    typedef enum logic [1:0] {
        SRC_A = 2'h0,
        SRC_B = 2'h1,
        SRC_C = 2'h2,
        SRC_D = 2'h3
    } source_t;
endpackage
`default_nettype wire

// >>> switch_config_registers.sv
/*
 * configuration register bank of a four-input video link switch: eight
 * byte registers reached from the serial slave engine, with pin-strapped
 * parallel control after reset and a per-register update-delay window.
 * assumes the serial protocol engine delivers decoded register reads and
 * writes as one-cycle strobes on clk, and that strap and pin inputs are
 * synchronous to clk.
 */
// How it works
// - every register here can be both written and read back by the serial host.
// - the low three bits of the slave address come from the three strap inputs.
// - the first serial access turns the parallel pin path off until the next reset.
// - fast path enable at 0 turns the fast channels off into standby, at 1 on.
// - fast path source select codes 00, 01, 10, 11 route sources A, B, C, D to the output.
// - side path enable at 0 switches the auxiliary path off, at 1 on.
// - side path source select picks auxiliary source A to D apart from the fast path, except under the pins, where both follow pin_source_sel.
// - termination master select at 0 opens every input termination switch.
// - termination master select at 1 lets each per-channel bit drive its own switch.
// - the cd termination register holds bits 15 to 8, the ab register bits 7 to 0.
// - a per-channel termination bit of 0 disconnects and 1 connects that channel.
// - output emphasis codes 00 to 11 give none, low, medium and high for all outputs.
// - writes inside an update window do not restart it and the last value lands at its end.
// - after reset the fast path enable and both source selects follow the parallel pins, with the side path held on, until the first serial event.
`timescale 1ns/1ps
`default_nettype none
`include "switch_cfg_defs.svh"

module switch_config_registers #(
    parameter int unsigned UPDATE_DELAY_CYC = `UPDATE_DELAY_CYC,
    parameter int unsigned NUM_REGS = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic slave_addr_strap_2,
    input wire logic slave_addr_strap_1,
    input wire logic slave_addr_strap_0,
    output logic [6:0] slave_address,
    input wire logic pin_fast_path_enable,
    input wire logic [1:0] pin_source_sel,
    output logic parallel_active,
    output logic fast_path_enable,
    output logic [1:0] fast_path_source_sel,
    output logic side_path_enable,
    output logic [1:0] side_path_source_sel,
    output logic [15:0] per_channel_termination,
    output logic [15:0] per_channel_equalization,
    output logic [1:0] output_emphasis_level,
    output logic output_termination_on,
    output logic output_current_level
);

    // ******************************************************
    // decoding helpers
    // ******************************************************
    function automatic logic addr_hit(input logic [7:0] a);
        case (a)
            `OFS_HIGH_SPEED_MODE_CTRL, `OFS_AUXILIARY_MODE_CTRL, `OFS_RECEIVER_SETTINGS,
            `OFS_INPUT_TERMINATION_AB, `OFS_INPUT_TERMINATION_CD, `OFS_RECEIVE_EQUALIZER_AB,
            `OFS_RECEIVE_EQUALIZER_CD, `OFS_TRANSMITTER_SETTINGS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    function automatic switch_cfg_pkg::reg_idx_t addr_idx(input logic [7:0] a);
        case (a)
            `OFS_HIGH_SPEED_MODE_CTRL: addr_idx = 3'h0;
            `OFS_AUXILIARY_MODE_CTRL: addr_idx = 3'h1;
            `OFS_RECEIVER_SETTINGS: addr_idx = 3'h2;
            `OFS_INPUT_TERMINATION_AB: addr_idx = 3'h3;
            `OFS_INPUT_TERMINATION_CD: addr_idx = 3'h4;
            `OFS_RECEIVE_EQUALIZER_AB: addr_idx = 3'h5;
            `OFS_RECEIVE_EQUALIZER_CD: addr_idx = 3'h6;
            default: addr_idx = 3'h7;
        endcase
    endfunction

    function automatic switch_cfg_pkg::reg_byte_t idx_mask(input int unsigned i);
        case (i)
            0, 1: idx_mask = `MASK_MODE_CTRL;
            2: idx_mask = `MASK_RECEIVER_SETTINGS;
            7: idx_mask = `MASK_TRANSMITTER_SETTINGS;
            default: idx_mask = `MASK_FULL;
        endcase
    endfunction

    function automatic switch_cfg_pkg::reg_byte_t idx_reset(input int unsigned i);
        case (i)
            0: idx_reset = `RST_HIGH_SPEED_MODE_CTRL;
            1: idx_reset = `RST_AUXILIARY_MODE_CTRL;
            2: idx_reset = `RST_RECEIVER_SETTINGS;
            3: idx_reset = `RST_INPUT_TERMINATION_AB;
            4: idx_reset = `RST_INPUT_TERMINATION_CD;
            5: idx_reset = `RST_RECEIVE_EQUALIZER_AB;
            6: idx_reset = `RST_RECEIVE_EQUALIZER_CD;
            default: idx_reset = `RST_TRANSMITTER_SETTINGS;
        endcase
    endfunction

    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] DELAY_LAST = (UPDATE_DELAY_CYC > 1) ?
        CNT_W'(UPDATE_DELAY_CYC - 1) : '0;

    switch_cfg_pkg::reg_byte_t serial_r [NUM_REGS];
    switch_cfg_pkg::reg_byte_t applied_r [NUM_REGS];
    switch_cfg_pkg::reg_byte_t source_val [NUM_REGS];
    logic parallel_r;
    logic [7:0] reg_rdata_r;
    logic reg_rvalid_r;
    logic [6:0] slave_address_r;

    // ******************************************************
    // serial register file
    // ******************************************************
    // reserved bits are masked on the way in, so the read path needs no mask
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_serial
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                serial_r[g] <= idx_reset(g);
            end else if (reg_wr && addr_hit(reg_addr) && addr_idx(reg_addr) == 3'(g)) begin
                serial_r[g] <= reg_wdata & idx_mask(g);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_r <= `READ_IDLE;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= addr_hit(reg_addr) ? serial_r[addr_idx(reg_addr)] : `READ_IDLE;
            end
        end
    end

    // ******************************************************
    // control path selection
    // ******************************************************
    // any strobe counts as a serial event, even to an unmapped offset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parallel_r <= 1'b1;
        end else if (reg_wr || reg_rd) begin
            parallel_r <= 1'b0;
        end
    end

    // straps are static; sampling them every cycle after release is enough
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slave_address_r <= '0;
        end else begin
            slave_address_r <= {`SLAVE_ADDR_UPPER, slave_addr_strap_2, slave_addr_strap_1,
                slave_addr_strap_0};
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            source_val[i] = serial_r[i];
        end
        if (parallel_r) begin
            source_val[0] = '0;
            source_val[0][`BIT_ENABLE] = pin_fast_path_enable;
            source_val[0][`SEL_HI:`SEL_LO] = pin_source_sel;
            source_val[1] = '0;
            source_val[1][`BIT_ENABLE] = 1'b1;
            source_val[1][`SEL_HI:`SEL_LO] = pin_source_sel;
        end
    end

    // ******************************************************
    // update-delay windows
    // ******************************************************
    // a change landing while idle applies at once and opens a window; changes
    // during the window only move the source, which is sampled at its end
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_window
        logic [CNT_W-1:0] count_r;
        logic busy_r;
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                applied_r[g] <= idx_reset(g);
                count_r <= '0;
                busy_r <= 1'b0;
            end else if (busy_r) begin
                if (count_r == DELAY_LAST) begin
                    applied_r[g] <= source_val[g];
                    busy_r <= 1'b0;
                    count_r <= '0;
                end else begin
                    count_r <= count_r + 1'b1;
                end
            end else if (source_val[g] != applied_r[g]) begin
                applied_r[g] <= source_val[g];
                busy_r <= 1'b1;
                count_r <= '0;
            end
        end
    end

    // ******************************************************
    // physical controls
    // ******************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_path_enable <= 1'b0;
            fast_path_source_sel <= switch_cfg_pkg::SRC_A;
            side_path_enable <= 1'b0;
            side_path_source_sel <= switch_cfg_pkg::SRC_A;
            per_channel_termination <= '0;
            per_channel_equalization <= '0;
            output_emphasis_level <= '0;
            output_termination_on <= 1'b0;
            output_current_level <= 1'b0;
        end else begin
            fast_path_enable <= applied_r[0][`BIT_ENABLE];
            fast_path_source_sel <= applied_r[0][`SEL_HI:`SEL_LO];
            side_path_enable <= applied_r[1][`BIT_ENABLE];
            side_path_source_sel <= applied_r[1][`SEL_HI:`SEL_LO];
            if (applied_r[2][`BIT_TERM_MASTER]) begin
                per_channel_termination <= {applied_r[4], applied_r[3]};
            end else begin
                per_channel_termination <= '0;
            end
            per_channel_equalization <= {applied_r[6], applied_r[5]};
            output_emphasis_level <= applied_r[7][`PE_HI:`PE_LO];
            output_termination_on <= applied_r[7][`BIT_OUT_TERM];
            output_current_level <= applied_r[7][`BIT_OUT_CURRENT];
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign reg_rvalid = reg_rvalid_r;
    assign slave_address = slave_address_r;
    assign parallel_active = parallel_r;

endmodule // switch_config_registers

`default_nettype wire

// >>> switch_config_registers_properties.sv
/* port assertions of the switch configuration bank.
   assumes it is bound into switch_config_registers. */
`timescale 1ns/1ps
`default_nettype none
module switch_config_registers_properties #(
    parameter int unsigned UPDATE_DELAY_CYC = 250
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic slave_addr_strap_2,
    input wire logic slave_addr_strap_1,
    input wire logic slave_addr_strap_0,
    input wire logic [6:0] slave_address,
    input wire logic parallel_active,
    input wire logic fast_path_enable,
    input wire logic [1:0] fast_path_source_sel,
    input wire logic side_path_enable,
    input wire logic [1:0] side_path_source_sel,
    input wire logic [15:0] per_channel_termination
);
    // one whole window plus pipeline: a write landing later is late
    localparam int MAXW = UPDATE_DELAY_CYC + 4;
    logic [7:0] mode0_r;
    logic [7:0] mode1_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence mode0_wr;
        reg_wr && reg_addr == 8'h00;
    endsequence
    sequence mode1_wr;
        reg_wr && reg_addr == 8'h01;
    endsequence
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) mode0_r <= 8'h00;
        else if (reg_wr && reg_addr == 8'h00) mode0_r <= reg_wdata;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) mode1_r <= 8'h00;
        else if (reg_wr && reg_addr == 8'h01) mode1_r <= reg_wdata;
    end
    read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
    read_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
    // the address flop lags the straps by one edge
    slave_addr_a: assert property ($past(rst_b) |->
        slave_address == {4'h9, $past(slave_addr_strap_2), $past(slave_addr_strap_1),
        $past(slave_addr_strap_0)}) else $error("bad address");
    serial_takeover_a: assert property (reg_wr || reg_rd |=> !parallel_active) else $error("pins kept");
    pins_stay_off_a: assert property (!parallel_active |=> !parallel_active) else $error("pins back");
    fast_apply_a: assert property (mode0_wr |-> ##[3:MAXW]
        fast_path_enable == mode0_r[6] && fast_path_source_sel == mode0_r[1:0]) else $error("fast path late");
    side_apply_a: assert property (mode1_wr |-> ##[3:MAXW]
        side_path_enable == mode1_r[6] && side_path_source_sel == mode1_r[1:0]) else $error("side path late");
    term_open_a: assert property (reg_wr && reg_addr == 8'h10 && !reg_wdata[0] |-> ##[3:MAXW]
        per_channel_termination == 16'h0000) else $error("termination kept");
    reserved_zero_a: assert property (reg_rvalid && $past(reg_addr) <= 8'h01 |->
        (reg_rdata & 8'hBC) == 8'h00) else $error("reserved bit set");
endmodule // switch_config_registers_properties
bind switch_config_registers switch_config_registers_properties #(.UPDATE_DELAY_CYC(UPDATE_DELAY_CYC)) i_props (
    .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slave_addr_strap_2(slave_addr_strap_2),
    .slave_addr_strap_1(slave_addr_strap_1), .slave_addr_strap_0(slave_addr_strap_0),
    .slave_address(slave_address), .parallel_active(parallel_active), .fast_path_enable(fast_path_enable),
    .fast_path_source_sel(fast_path_source_sel), .side_path_enable(side_path_enable),
    .side_path_source_sel(side_path_source_sel), .per_channel_termination(per_channel_termination));
`default_nettype wire

// >>> tb.sv
/* testbench: host model driving the bank, outputs compared per row.
   assumes a short update window so the run stays small. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int W = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic pin_en = 1'b1;
    logic [1:0] pin_sel = 2'h2;
    logic [2:0] strap = 3'h5;
    logic reg_wr, reg_rd, rvalid, par, fe, se, to, cl;
    logic [7:0] addr, wdata, rdata, d;
    logic [6:0] saddr;
    logic [1:0] fs, ss, pe;
    logic [15:0] term, eq;
    int error_cnt = 0;
    int num_checks = 0;
    logic [15:0] rst_tab [8] = '{16'h0040, 16'h0140, 16'h1001, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h2003};
    // row: offset, write byte, read back, output group, group value
    logic [43:0] rows [17] = '{44'h00FF4300007, 44'h00010100001, 44'h00424200006, 44'h01030310003,
        44'h01424210006, 44'h01414110005, 44'h11A5A5200A5, 44'h123C3C23CA5, 44'h10FE0020000,
        44'h10010123CA5, 44'h135A5A3005A, 44'h14C3C33C35A, 44'h20FF0F4000F, 44'h20040440004,
        44'h20080840008, 44'h20000040000, 44'h30FF0040000};
    always #2 clk = ~clk;
    switch_cfg_host i_host (.clk(clk), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(addr), .reg_wdata(wdata));
    switch_config_registers #(.UPDATE_DELAY_CYC(W)) i_dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .slave_addr_strap_2(strap[2]), .slave_addr_strap_1(strap[1]), .slave_addr_strap_0(strap[0]),
        .slave_address(saddr),
        .pin_fast_path_enable(pin_en), .pin_source_sel(pin_sel), .parallel_active(par), .fast_path_enable(fe),
        .fast_path_source_sel(fs), .side_path_enable(se), .side_path_source_sel(ss), .per_channel_termination(term),
        .per_channel_equalization(eq), .output_emphasis_level(pe), .output_termination_on(to),
        .output_current_level(cl));
    // ****
    // helpers
    // ****
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [15:0] obs(input logic [3:0] g);
        case (g)
            4'h0: return {13'h0000, fe, fs};
            4'h1: return {13'h0000, se, ss};
            4'h2: return term;
            4'h3: return eq;
            default: return {12'h000, pe, to, cl};
        endcase
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        tick(20);
        chk("slave addr", {9'h000, saddr}, 16'h004D);
        chk("pin fast", {fe, fs}, 16'h0006);
        @(posedge clk);
        pin_en <= 1'b0;
        pin_sel <= 2'h1;
        tick(20);
        chk("pin modes", {fe, fs, se, ss, par}, 16'h001B);
        foreach (rst_tab[i]) begin
            i_host.rd(rst_tab[i][15:8], d);
            chk("reset value", d, rst_tab[i][7:0]);
        end
        tick(20);
        chk("serial modes", {fe, fs, se, ss, par}, 16'h0048);
        foreach (rows[i]) begin
            i_host.wr(rows[i][43:36], rows[i][35:28]);
            i_host.rd(rows[i][43:36], d);
            chk("read back", d, rows[i][27:20]);
            tick(W + 8);
            chk("outputs", obs(rows[i][19:16]), rows[i][15:0]);
        end
        // writes inside the window: the first value holds, the last lands unrestarted
        i_host.wr(8'h20, 8'h0C);
        i_host.wr(8'h20, 8'h04);
        i_host.wr(8'h20, 8'h08);
        #1;
        chk("held emphasis", obs(4'h4), 16'h000C);
        tick(W);
        chk("last emphasis", obs(4'h4), 16'h0008);
        @(posedge clk);
        rst_b <= 1'b0;
        tick(2);
        chk("in reset", {fe, se, par}, 16'h0001);
        @(posedge clk);
        rst_b <= 1'b1;
        tick(20);
        chk("pins again", {fe, fs, par}, 16'h0003);
        i_host.rd(8'h20, d);
        chk("tx reset", d, 16'h0003);
        @(posedge clk);
        strap <= 3'h2;
        tick(3);
        chk("slave addr", {9'h000, saddr}, 16'h004A);
        results();
    end
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule // tb
`default_nettype wire
